// ===== dv/core_regs_model.sv
// Core-side writer of the working registers
`timescale 1ns/1ps
`default_nettype none
module core_regs_model
(
  // Clock
  input  wire logic      mclk,
  // Register write port
  output var logic       wr_en = 1'b0,
  output var logic [3:0] wr_sel = 4'h0,
  output var logic [7:0] wr_data = 8'h00
);
  // Shadow the bench predicts from
  logic [7:0] regs [16];
  // One write a cycle, held until its edge
  task automatic put(input logic [3:0] sel, input logic [7:0] d);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    regs[sel] = d;
    @(posedge mclk);
    #1;
  endtask
  // Idle: stale data inverted, never left frozen
  task automatic done();
    wr_en = 1'b0;
    wr_data = ~wr_data;
  endtask
endmodule // core_regs_model
`default_nettype wire

// ===== dv/oag_assertions.sv
// Timing and value checks on the address generator ports
`timescale 1ns/1ps
`default_nettype none
module oag_assertions
  import oag_pkg::*;
(
  // Request side
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire instr_e      instr,
  input wire mode_e       mode,
  input wire logic [7:0]  field8,
  input wire logic [15:0] field16,
  input wire logic [15:0] next_pc_in,
  // Result side
  input wire logic        result_valid,
  input wire logic        mode_error,
  input wire target_e     target,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] new_pc,
  input wire logic [7:0]  operand
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Memory loads and sign-extended short field
  logic        mem_ld;
  logic [15:0] disp;
  assign mem_ld = instr == program_mem_load_instr || instr == external_data_load_instr;
  assign disp = {{8{field8[7]}}, field8};
  ////////////////////////////////////////////////////////////////////////////
  latency_two_a: assert property (req_valid |-> ##2 result_valid)
    else $error("late result");
  error_refused_a: assert property (mode_error |-> result_valid && target == target_none)
    else $error("bad refusal");
  rel_target_a: assert property (req_valid && mode == relative_address_mode &&
    instr == relative_jump_instr |-> ##2 new_pc == $past(next_pc_in, 2) + $past(disp, 2))
    else $error("bad branch target");
  rel_only_a: assert property (req_valid && mode == relative_address_mode &&
    instr != relative_jump_instr |-> ##2 mode_error) else $error("relative misuse");
  imm_value_a: assert property (req_valid && mode == immediate_operand_mode
    |-> ##2 operand == $past(field8, 2) && !mode_error) else $error("bad immediate");
  direct_jump_a: assert property (req_valid && mode == direct_address_mode &&
    (instr == absolute_jump_instr || instr == call_instr)
    |-> ##2 target == target_pc && new_pc == $past(field16, 2)) else $error("bad jump");
  direct_load_a: assert property (req_valid && mode == direct_address_mode && mem_ld
    |-> ##2 target == target_memory && mem_addr == $past(field16, 2)) else $error("bad load");
  index_only_a: assert property (req_valid && (mode == indexed_mem_short_mode && !mem_ld ||
    mode == indexed_rf_mode && instr != register_load_instr) |-> ##2 mode_error)
    else $error("index misuse");
endmodule // oag_assertions
bind operand_address_generator oag_assertions i_chk (.mclk, .reset, .req_valid, .instr,
  .mode, .field8, .field16, .next_pc_in, .result_valid, .mode_error, .target, .mem_addr,
  .new_pc, .operand);
`default_nettype wire

// ===== dv/operand_address_generator_test.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_test
  import oag_pkg::*;
;
  logic        mclk = 0, reset = 1, req_valid = 0, use_pair = 0, result_valid, mode_error;
  logic        wr_en;
  logic [3:0]  wr_sel, reg_sel = 0;
  logic [7:0]  wr_data, field8 = 0, rf_addr, operand;
  logic [15:0] field16 = 0, next_pc_in = 0, mem_addr, new_pc, rnd = 16'h52C0;
  instr_e      instr = register_load_instr;
  mode_e       mode = indirect_register_mode;
  target_e     target;
  logic [18:0] notes [$];
  logic [18:0] seen;
  int          n_fail = 0, num_checks = 0, cycles = 0;
  operand_address_generator i_dut (.mclk, .reset, .req_valid, .instr, .mode, .reg_sel,
    .use_pair, .field8, .field16, .next_pc_in, .wr_en, .wr_sel, .wr_data, .result_valid,
    .mode_error, .target, .rf_addr, .mem_addr, .new_pc, .operand);
  core_regs_model i_regs (.mclk, .wr_en, .wr_sel, .wr_data);
  ////////////////////////////////////////////////////////////////////////////
  initial
  forever #20 mclk = ~mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected {error, target, value}; errors carry no value
  function automatic logic [18:0] predict();
    logic [7:0]  r;
    logic [15:0] pair, sx;
    logic        mem;
    r = i_regs.regs[reg_sel];
    pair = {i_regs.regs[{reg_sel[3:1], 1'b0}], i_regs.regs[{reg_sel[3:1], 1'b1}]};
    sx = {{8{field8[7]}}, field8};
    mem = instr == program_mem_load_instr || instr == external_data_load_instr;
    case (mode)
      indirect_register_mode: return use_pair ? {3'h2, pair} : {3'h1, 8'h00, r};
      indexed_rf_mode: return instr == register_load_instr ? {3'h1, 8'h00, field8 + r} : 19'h40000;
      indexed_mem_short_mode: return mem ? {3'h2, pair + sx} : 19'h40000;
      indexed_mem_long_mode: return mem ? {3'h2, pair + field16} : 19'h40000;
      direct_address_mode: return mem ? {3'h2, field16} : (instr == absolute_jump_instr ||
        instr == call_instr) ? {3'h3, field16} : 19'h40000;
      relative_address_mode: return instr == relative_jump_instr ?
        {3'h3, next_pc_in + sx} : 19'h40000;
      immediate_operand_mode: return {3'h0, 8'h00, field8};
      default: return 19'h40000;
    endcase
  endfunction
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Back-to-back request, note queued as it is driven
  task automatic request(input mode_e m, input instr_e i);
    rnd = lfsr(rnd);
    req_valid = 1;
    mode = m;
    instr = i;
    {field8, use_pair, reg_sel} = {rnd[15:8], rnd[4:0]};
    field16 = lfsr(rnd);
    next_pc_in = {rnd[7:0], rnd[15:8]};
    notes.push_back(predict());
    @(posedge mclk);
    #1;
  endtask
  // Oldest note against each result; the picked value follows the target
  always @(posedge mclk)
    if (!reset && result_valid === 1'b1)
    begin
      seen = {mode_error, target, mode_error ? 16'h0 : target == target_regfile ? {8'h00, rf_addr}
        : target == target_memory ? mem_addr : target == target_pc ? new_pc : {8'h00, operand}};
      check(seen, notes.pop_front());
    end
  // Hang guard, far above the roughly 152 cycles needed
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_fail++;
      results();
    end
  end
  // Every mode with every instruction, twice with fresh registers
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 reset = 0;
    for (int p = 0; p < 2; p++)
    begin
      for (int r = 0; r < 16; r++)
      begin
        rnd = lfsr(rnd);
        i_regs.put(r[3:0], rnd[7:0]);
      end
      i_regs.done();
      for (int m = 0; m < 8; m++)
        for (int i = 0; i < 6; i++)
          request(mode_e'(m), instr_e'(i));
      req_valid = 0;
      repeat (4) @(posedge mclk);
      #1;
      check(19'(notes.size()), 19'h00000);
      $display("test pass %0d done", p);
    end
    results();
  end
endmodule // operand_address_generator_test
`default_nettype wire

// ===== rtl/oag_map.svh
// Constants for the operand address generator
`ifndef OAG_MAP_SVH
`define OAG_MAP_SVH
`define OAG_RF_AW        8
`define OAG_MEM_AW       16
`define OAG_PAIR_MSB_ODD 1'b0
`define OAG_RESET_ADDR   16'h0000
`define OAG_RESET_BYTE   8'h00
`define OAG_PORT_REGS    16
`endif

// ===== rtl/oag_pkg.sv
// Types for the operand address generator
package oag_pkg;
  typedef enum logic [2:0] {
    indirect_register_mode,
    indexed_rf_mode,
    indexed_mem_short_mode,
    indexed_mem_long_mode,
    direct_address_mode,
    relative_address_mode,
    immediate_operand_mode
  } mode_e;

  typedef enum logic [2:0] {
    register_load_instr,
    program_mem_load_instr,
    external_data_load_instr,
    absolute_jump_instr,
    call_instr,
    relative_jump_instr
  } instr_e;

  typedef enum logic [1:0] {
    target_none,
    target_regfile,
    target_memory,
    target_pc
  } target_e;
endpackage : oag_pkg

// ===== rtl/operand_address_generator.sv
// Operand effective-address generator for an 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "oag_map.svh"
module operand_address_generator
  import oag_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Decoded instruction fields
  input  wire logic        req_valid,
  input  wire instr_e      instr,
  input  wire mode_e       mode,
  input  wire logic [3:0]  reg_sel,
  input  wire logic        use_pair,
  input  wire logic [7:0]  field8,
  input  wire logic [15:0] field16,
  input  wire logic [15:0] next_pc_in,
  // Working register writes
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_sel,
  input  wire logic [7:0]  wr_data,
  // Results
  output var logic         result_valid,
  output var logic         mode_error,
  output var target_e      target,
  output var logic [7:0]   rf_addr,
  output var logic [15:0]  mem_addr,
  output var logic [15:0]  new_pc,
  output var logic [7:0]   operand
);
  typedef struct packed {
    logic        pend;
    instr_e      instr;
    mode_e       mode;
    logic        use_pair;
    logic [7:0]  field8;
    logic [15:0] field16;
    logic [15:0] pc;
    logic        result_valid;
    logic        mode_error;
    target_e     target;
    logic [7:0]  rf_addr;
    logic [15:0] mem_addr;
    logic [15:0] new_pc;
    logic [7:0]  operand;
  } state_s;

  state_s st;
  state_s next_st;
  reg_pair_if wr_if ();

  ////////////////////////////////////////////////////////////////////////
  // Register reads take one cycle, so requests are held one stage
  // Low select bit is dropped for pair reads inside the bank
  assign wr_if.sel = reg_sel;

  working_regs #(.NREGS(`OAG_PORT_REGS)) u_regs (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (wr_en),
    .wr_sel  (wr_sel),
    .wr_data (wr_data),
    .rd      (wr_if.reader)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address formation
  always_comb
  begin
    logic mem_load;
    logic jump;
    logic [15:0] sext;
    mem_load = 1'b0;
    jump = 1'b0;
    sext = {{8{st.field8[7]}}, st.field8};
    next_st = st;
    next_st.pend = req_valid;
    next_st.instr = instr;
    next_st.mode = mode;
    next_st.use_pair = use_pair;
    next_st.field8 = field8;
    next_st.field16 = field16;
    // Core has already stepped the PC past the branch
    next_st.pc = next_pc_in;
    next_st.result_valid = st.pend;
    next_st.mode_error = 1'b0;
    next_st.target = target_none;
    mem_load = (st.instr == program_mem_load_instr) ||
               (st.instr == external_data_load_instr);
    jump = (st.instr == absolute_jump_instr) || (st.instr == call_instr);
    if (st.pend)
    begin
      unique case (st.mode)
        indirect_register_mode:
        begin
          // Byte register points in the file, pair points in memory
          if (st.use_pair)
          begin
            next_st.target = target_memory;
            next_st.mem_addr = wr_if.pair_val;
          end
          else
          begin
            next_st.target = target_regfile;
            next_st.rf_addr = wr_if.byte_val;
          end
        end
        indexed_rf_mode:
        begin
          if (st.instr == register_load_instr)
          begin
            next_st.target = target_regfile;
            // Kept at 8 bits so the index wraps inside the file
            next_st.rf_addr = st.field8 + wr_if.byte_val;
          end
          else
            next_st.mode_error = 1'b1;
        end
        indexed_mem_short_mode:
        begin
          if (mem_load)
          begin
            next_st.target = target_memory;
            next_st.mem_addr = wr_if.pair_val + sext;
          end
          else
            next_st.mode_error = 1'b1;
        end
        indexed_mem_long_mode:
        begin
          if (mem_load)
          begin
            next_st.target = target_memory;
            next_st.mem_addr = wr_if.pair_val + st.field16;
          end
          else
            next_st.mode_error = 1'b1;
        end
        direct_address_mode:
        begin
          if (jump)
          begin
            next_st.target = target_pc;
            next_st.new_pc = st.field16;
          end
          else if (mem_load)
          begin
            // Same address serves a source or a destination
            next_st.target = target_memory;
            next_st.mem_addr = st.field16;
          end
          else
            next_st.mode_error = 1'b1;
        end
        relative_address_mode:
        begin
          if (st.instr == relative_jump_instr)
          begin
            next_st.target = target_pc;
            // Wraps at the top of the 64K space, no carry out
            next_st.new_pc = st.pc + sext;
          end
          else
            next_st.mode_error = 1'b1;
        end
        immediate_operand_mode:
        begin
          next_st.target = target_none;
          // No lookup: the field itself is the operand
          next_st.operand = st.field8;
        end
        // Spare code is refused rather than guessed at
        default:
          next_st.mode_error = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
      // Enum fields named explicitly, not left to the zero fill
      st.instr <= register_load_instr;
      st.mode <= indirect_register_mode;
      st.target <= target_none;
    end
    else
      st <= next_st;
  end

  // Outputs straight from the state flops
  assign result_valid = st.result_valid;
  assign mode_error   = st.mode_error;
  assign target       = st.target;
  assign rf_addr      = st.rf_addr;
  assign mem_addr     = st.mem_addr;
  assign new_pc       = st.new_pc;
  assign operand      = st.operand;
endmodule : operand_address_generator
`default_nettype wire

// ===== rtl/reg_pair_if.sv
// Interface carrying working register reads between the top and its pair reader
`timescale 1ns/1ps
`default_nettype none
interface reg_pair_if;
  logic [3:0] sel;
  logic [7:0] byte_val;
  logic [15:0] pair_val;
  modport reader (input sel, output byte_val, output pair_val);
  modport user (output sel, input byte_val, input pair_val);
endinterface : reg_pair_if
`default_nettype wire

// ===== rtl/working_regs.sv
// Working register bank with registered byte and pair read ports
`timescale 1ns/1ps
`default_nettype none
`include "oag_map.svh"
module working_regs
  import oag_pkg::*;
#(
  parameter int NREGS = `OAG_PORT_REGS
)(
  // Clock and reset
  input  wire logic     mclk,
  input  wire logic     reset,
  // Register write from the core
  input  wire logic     wr_en,
  input  wire logic [3:0] wr_sel,
  input  wire logic [7:0] wr_data,
  // Read side
  reg_pair_if.reader    rd
);
  logic [7:0] mem [NREGS];
  logic [7:0] byte_q;
  logic [15:0] pair_q;
  logic [3:0] even_sel;
  logic [3:0] odd_sel;

  ////////////////////////////////////////////////////////////////////////
  // Pair starts on even register, high byte first
  assign even_sel = {rd.sel[3:1], `OAG_PAIR_MSB_ODD};
  assign odd_sel  = {rd.sel[3:1], 1'b1};

  // Storage and registered reads
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      byte_q <= `OAG_RESET_BYTE;
      pair_q <= `OAG_RESET_ADDR;
    end
    else
    begin
      byte_q <= mem[rd.sel];
      pair_q <= {mem[even_sel], mem[odd_sel]};
    end
  end

  // Plain array write; contents undefined after reset like the real file
  always_ff @(posedge mclk)
  begin
    if (wr_en)
      mem[wr_sel] <= wr_data;
  end

  assign rd.byte_val = byte_q;
  assign rd.pair_val = pair_q;
endmodule : working_regs
`default_nettype wire
